// >>> common/frame_if.sv
// Valid/ready channel carrying one mapped frame.
`timescale 1ns/1ps
interface frame_if #(parameter int WIDTH = 8) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : frame_if

// >>> common/mapper_defs.svh
// Constants for the transport-layer sample mapper.
// How it works
// - Mode 4: three lanes, two octets each, A0 B0 C0 D0 packed across them.
// - Mode 5: two lanes, lane 0 carries A0 then B0, lane 1 C0 then D0.
// - Mode 6: six lanes; A0 A1 B0 B1 over lanes 0-2, C and D over 3-5.
// - Mode 7: one octet per lane; lanes 0-3 carry sample 0 of A to D.
// - Mode 8: three octets per lane, two samples of one channel per lane.
// - Mode 9: one octet per lane; even lane even sample, odd lane odd sample.
// - Mode 10: five octets per lane; even lane samples 0,2,4,6, odd lane 1,3,5,7.
// - Mode 11: eight octets per lane, five samples plus tail; A on 0-3, B on 4-7.
// - Every tail bit is driven as zero.
// - Samples are placed most significant bit first.
// - Only the lowest lanes a mode needs are powered; the rest are off.
`ifndef MAPPER_DEFS_SVH
`define MAPPER_DEFS_SVH
`define NUM_CH       4
`define NUM_LANES    8
`define SLOTS        20
`define SMP_W        12
`define LANE_W       64
`define FIFO_DEPTH   16
`define MODE_W       4
`define RES8         8
`define RES10        10
`define TAIL         4'h0
`define MODE_RST     4'h0
`define MODE_12B_3L  4'h4
`define MODE_8B_2L   4'h5
`define MODE_12B_6L  4'h6
`define MODE_8B_4L   4'h7
`define MODE_12B_4L  4'h8
`define MODE_8B_8L   4'h9
`define MODE_10B_8L  4'ha
`define MODE_12B_DL  4'hb
`define PWR_OFF      8'h00
`define PWR_2L       8'h03
`define PWR_3L       8'h07
`define PWR_4L       8'h0f
`define PWR_6L       8'h3f
`define PWR_8L       8'hff
`define OCT_0        4'h0
`define OCT_1        4'h1
`define OCT_2        4'h2
`define OCT_3        4'h3
`define OCT_5        4'h5
`define OCT_8        4'h8
`endif

// >>> common/mapper_pkg.sv
// Types used by the sample mapper; the frame buffer does not import them.
package mapper_pkg;
`include "mapper_defs.svh"
  typedef logic [`SMP_W-1:0]                sample_t;
  typedef sample_t [`SLOTS-1:0]             chan_t;
  typedef chan_t [`NUM_CH-1:0]              samples_t;
  typedef logic [`LANE_W-1:0]               lane_t;
  typedef lane_t [`NUM_LANES-1:0]           frame_t;
  typedef logic [`MODE_W-1:0]               mode_t;
endpackage : mapper_pkg

// >>> hw/frame_fifo.sv
// Frame buffer with a registered head word and a registered ready.
`timescale 1ns/1ps
module frame_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  frame_if.snk     wr,
  frame_if.src     rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             in_ready;
  logic             out_valid;
  logic [WIDTH-1:0] out_data;
  wire              push = wr.valid && in_ready;
  wire              pop  = (count != '0) && (!out_valid || rd.ready);

  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign wr.ready   = in_ready;
  assign rd.valid   = out_valid;
  assign rd.data    = out_data;

  // Ready is registered from the next fill level, so it never promises a slot it lacks.
  always_ff @(posedge clk) begin
    if (rst) begin
      wp        <= '0;
      rp        <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp        <= push ? wp + 1'b1 : wp;
      rp        <= pop ? rp + 1'b1 : rp;
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= pop || (out_valid && !rd.ready);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= wr.data;
    end
    if (pop) begin
      out_data <= mem[rp];
    end
  end
endmodule : frame_fifo

// >>> hw/transport_layer_sample_mapper.sv
// Packs one frame of quad-channel samples into lane octets for link modes 4 to 11.
`timescale 1ns/1ps
`include "mapper_defs.svh"
module transport_layer_sample_mapper
  import mapper_pkg::*;
(
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic                                link_enable,
  input  wire logic [`MODE_W-1:0]                  link_mode_select,
  input  wire logic                                sample_valid,
  input  wire logic [`NUM_CH*`SLOTS*`SMP_W-1:0]    sample_data,
  output wire logic                                sample_ready,
  output wire logic                                lane_valid,
  output wire logic [`NUM_LANES*`LANE_W-1:0]       lane_data,
  input  wire logic                                lane_ready,
  output logic      [`NUM_LANES-1:0]               lane_power,
  output logic      [`MODE_W-1:0]                  active_mode,
  output logic      [`MODE_W-1:0]                  frame_octets,
  output logic                                     mode_error
);
  localparam int FRAME_W = `NUM_LANES * `LANE_W;

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  samples_t                  smp;
  frame_t                    mapped;
  mode_t                     next_mode;
  logic [`NUM_LANES-1:0]     next_power;
  logic [`MODE_W-1:0]        next_octets;
  logic [4*`SMP_W-1:0]       grp4;
  logic [`NUM_LANES*4-1:0]   tails;

  assign smp  = sample_data;
  assign grp4 = {smp[0][0], smp[1][0], smp[2][0], smp[3][0]};

  // A running link keeps its mode; a new value is taken only while it is off.
  assign next_mode = link_enable ? active_mode : link_mode_select;

  assign next_power =
    (next_mode == `MODE_12B_3L) ? `PWR_3L :
    (next_mode == `MODE_8B_2L)  ? `PWR_2L :
    (next_mode == `MODE_12B_6L) ? `PWR_6L :
    (next_mode == `MODE_8B_4L)  ? `PWR_4L :
    (next_mode == `MODE_12B_4L) ? `PWR_4L :
    (next_mode == `MODE_8B_8L)  ? `PWR_8L :
    (next_mode == `MODE_10B_8L) ? `PWR_8L :
    (next_mode == `MODE_12B_DL) ? `PWR_8L : `PWR_OFF;

  assign next_octets =
    (next_mode == `MODE_12B_3L) ? `OCT_2 :
    (next_mode == `MODE_8B_2L)  ? `OCT_2 :
    (next_mode == `MODE_12B_6L) ? `OCT_2 :
    (next_mode == `MODE_8B_4L)  ? `OCT_1 :
    (next_mode == `MODE_12B_4L) ? `OCT_3 :
    (next_mode == `MODE_8B_8L)  ? `OCT_1 :
    (next_mode == `MODE_10B_8L) ? `OCT_5 :
    (next_mode == `MODE_12B_DL) ? `OCT_8 : `OCT_0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_mode  <= `MODE_RST;
      lane_power   <= `PWR_OFF;
      frame_octets <= `OCT_0;
      mode_error   <= 1'b1;
    end else begin
      active_mode  <= next_mode;
      lane_power   <= next_power;
      frame_octets <= next_octets;
      mode_error   <= next_power == `PWR_OFF;
    end
  end

  // ****************************************************************
  // Per-lane packing
  // ****************************************************************
  // Octet 0 of a lane sits in the top byte, so shifting a lane out from its
  // top bit sends every sample most significant bit first.
  for (genvar l = 0; l < `NUM_LANES; l++) begin : g_lane
    localparam int P3  = l % 3;
    localparam int G6  = (l < 6) ? 2 * (l / 3) : 0;
    localparam int C5  = (l < 2) ? 2 * l : 0;
    localparam int C7  = (l < 4) ? l : 0;
    localparam int C9  = l / 2;
    localparam int K9  = l % 2;
    localparam int C11 = l / 4;
    localparam int K11 = l % 4;

    logic [4*`SMP_W-1:0] grp6;
    lane_t               m4;
    lane_t               m5;
    lane_t               m6;
    lane_t               m7;
    lane_t               m8;
    lane_t               m9;
    lane_t               m10;
    lane_t               m11;

    assign grp6 = {smp[G6][0], smp[G6][1], smp[G6+1][0], smp[G6+1][1]};
    assign tails[4*l +: 4] = mapped[l][3:0];

    assign m4 = (l < 3) ? {grp4[47-16*P3 -: 16], 48'h0} : '0;
    assign m5 = (l < 2) ? {smp[C5][0][`RES8-1:0],
                           smp[C5+1][0][`RES8-1:0], 48'h0} : '0;
    assign m6 = (l < 6) ? {grp6[47-16*P3 -: 16], 48'h0} : '0;
    assign m7 = (l < 4) ? {smp[C7][0][`RES8-1:0], 56'h0} : '0;
    assign m8 = (l < 4) ? {smp[C7][0], smp[C7][1], 40'h0} : '0;
    assign m9 = {smp[C9][K9][`RES8-1:0], 56'h0};
    assign m10 = {smp[C9][K9][`RES10-1:0], smp[C9][K9+2][`RES10-1:0],
                  smp[C9][K9+4][`RES10-1:0], smp[C9][K9+6][`RES10-1:0],
                  24'h0};
    assign m11 = {smp[C11][K11], smp[C11][K11+4], smp[C11][K11+8],
                  smp[C11][K11+12], smp[C11][K11+16], `TAIL};

    // Unused octets and lanes stay zero so a powered-down lane carries nothing.
    assign mapped[l] =
      (active_mode == `MODE_12B_3L) ? m4  :
      (active_mode == `MODE_8B_2L)  ? m5  :
      (active_mode == `MODE_12B_6L) ? m6  :
      (active_mode == `MODE_8B_4L)  ? m7  :
      (active_mode == `MODE_12B_4L) ? m8  :
      (active_mode == `MODE_8B_8L)  ? m9  :
      (active_mode == `MODE_10B_8L) ? m10 :
      (active_mode == `MODE_12B_DL) ? m11 : '0;
  end

  // ****************************************************************
  // Frame buffer
  // ****************************************************************
  frame_if #(.WIDTH(FRAME_W)) wr_if ();
  frame_if #(.WIDTH(FRAME_W)) rd_if ();

  // Frames offered while the link is off or the mode is unsupported are
  // accepted and dropped, so the sample source never hangs on a dead link.
  assign wr_if.valid  = sample_valid && link_enable && !mode_error;
  assign wr_if.data   = mapped;
  assign sample_ready = wr_if.ready;
  assign lane_valid   = rd_if.valid;
  assign lane_data    = rd_if.data;
  assign rd_if.ready  = lane_ready;

  frame_fifo #(
    .WIDTH (FRAME_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk (ref_clk),
    .rst (rst),
    .wr  (wr_if.snk),
    .rd  (rd_if.src)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_mode4;
    active_mode == `MODE_12B_3L |->
      mapped[0][63:48] == {smp[0][0], smp[1][0][11:8]} &&
      mapped[1][63:48] == {smp[1][0][7:0], smp[2][0][11:4]};
  endproperty
  a_mode4: assert property (p_mode4) else $error("mode 4 packing wrong");

  property p_mode5;
    active_mode == `MODE_8B_2L |->
      mapped[1] == {smp[2][0][7:0], smp[3][0][7:0], 48'h0} && mapped[2] == '0;
  endproperty
  a_mode5: assert property (p_mode5) else $error("mode 5 packing wrong");

  property p_mode6;
    active_mode == `MODE_12B_6L |->
      mapped[5][63:48] == {smp[3][0][3:0], smp[3][1]} && mapped[6] == '0;
  endproperty
  a_mode6: assert property (p_mode6) else $error("mode 6 packing wrong");

  property p_mode7;
    active_mode == `MODE_8B_4L |-> mapped[3] == {smp[3][0][7:0], 56'h0};
  endproperty
  a_mode7: assert property (p_mode7) else $error("mode 7 packing wrong");

  property p_mode8;
    active_mode == `MODE_12B_4L |-> mapped[2][63:40] == {smp[2][0], smp[2][1]};
  endproperty
  a_mode8: assert property (p_mode8) else $error("mode 8 packing wrong");

  property p_mode9;
    active_mode == `MODE_8B_8L |-> mapped[7][63:56] == smp[3][1][7:0];
  endproperty
  a_mode9: assert property (p_mode9) else $error("mode 9 packing wrong");

  property p_mode10;
    active_mode == `MODE_10B_8L |->
      mapped[1][63:24] == {smp[0][1][9:0], smp[0][3][9:0], smp[0][5][9:0], smp[0][7][9:0]};
  endproperty
  a_mode10: assert property (p_mode10) else $error("mode 10 packing wrong");

  property p_mode11;
    active_mode == `MODE_12B_DL |->
      mapped[5][63:52] == smp[1][1] && mapped[5][15:4] == smp[1][17];
  endproperty
  a_mode11: assert property (p_mode11) else $error("mode 11 packing wrong");

  property p_tail;
    !mode_error |-> tails == '0;
  endproperty
  a_tail: assert property (p_tail) else $error("tail bits not zero");

  property p_msb;
    active_mode == `MODE_8B_4L |-> mapped[0][63] == smp[0][0][7];
  endproperty
  a_msb: assert property (p_msb) else $error("sample not MSB first");

  property p_power;
    !link_enable && link_mode_select == `MODE_12B_3L |=> lane_power == `PWR_3L;
  endproperty
  a_power: assert property (p_power) else $error("wrong lanes powered");

  property p_hold;
    link_enable |=> active_mode == $past(active_mode) && $stable(lane_power);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed while link on");

  property p_stall;
    lane_valid && !lane_ready |=> lane_valid && $stable(lane_data);
  endproperty
  a_stall: assert property (p_stall) else $error("stalled frame changed");

  c_mode11: cover property (wr_if.valid && wr_if.ready && active_mode == `MODE_12B_DL);
  c_full:   cover property (link_enable && !sample_ready);
  c_change: cover property (!link_enable ##1 active_mode != $past(active_mode));
endmodule : transport_layer_sample_mapper

// >>> tb/lane_sink.sv
// Far-side receiver model that takes mapped frames behind a stalling ready.
`timescale 1ns/1ps
module lane_sink (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic halt,
  output logic      lane_ready
);
  logic [15:0] rnd;
  // A real receiver pauses at will; random ready keeps the held head word busy.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rnd        <= 16'h1d2b;
      lane_ready <= 1'b0;
    end else begin
      rnd        <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      lane_ready <= !halt && (rnd[0] | rnd[3]);
    end
  end
endmodule : lane_sink

// >>> tb/tb.sv
// Self-checking bench for the sample mapper with a stalling far-side model.
`timescale 1ns/1ps
`include "mapper_defs.svh"
module tb;
  import mapper_pkg::*;
  logic         ref_clk, rst, link_enable, sample_valid, sample_ready, halt;
  logic         lane_valid, lane_ready, mode_error;
  logic [3:0]   link_mode_select, active_mode, frame_octets, cur_mode;
  logic [7:0]   lane_power;
  logic [959:0] sample_data;
  logic [511:0] lane_data;
  logic [511:0] exp_q[$];
  logic [511:0] e;
  logic [31:0]  seed;
  int           err_total, n_checks;

  transport_layer_sample_mapper uut (
    .ref_clk(ref_clk), .rst(rst), .link_enable(link_enable),
    .link_mode_select(link_mode_select), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready), .lane_valid(lane_valid),
    .lane_data(lane_data), .lane_ready(lane_ready), .lane_power(lane_power),
    .active_mode(active_mode), .frame_octets(frame_octets), .mode_error(mode_error)
  );
  lane_sink sink (.ref_clk(ref_clk), .rst(rst), .halt(halt), .lane_ready(lane_ready));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Expected frames
  // ****************************************
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // Sample width, bits per lane, item count, items per lane (modes 4 to 6 set it to the item count and pack across lanes), powered lanes.
  function automatic void mode_tab(input logic [3:0] m, output int w, lb, n, ipl,
                                   output logic [7:0] pw);
    case (m)
      4'h4: begin w = 12; lb = 16; n = 4; ipl = 4; pw = 8'h07; end
      4'h5: begin w = 8; lb = 16; n = 4; ipl = 4; pw = 8'h03; end
      4'h6: begin w = 12; lb = 16; n = 8; ipl = 8; pw = 8'h3f; end
      4'h7: begin w = 8; lb = 8; n = 4; ipl = 1; pw = 8'h0f; end
      4'h8: begin w = 12; lb = 24; n = 8; ipl = 2; pw = 8'h0f; end
      4'h9: begin w = 8; lb = 8; n = 8; ipl = 1; pw = 8'hff; end
      4'ha: begin w = 10; lb = 40; n = 32; ipl = 4; pw = 8'hff; end
      4'hb: begin w = 12; lb = 64; n = 40; ipl = 5; pw = 8'hff; end
      default: begin w = 0; lb = 0; n = 0; ipl = 1; pw = 8'h00; end
    endcase
  endfunction : mode_tab

  // Items form one stream cut into lanes; untouched bits stay zero as tail.
  function automatic logic [511:0] exp_frame(logic [3:0] m, logic [959:0] s);
    logic [511:0] f;
    logic [11:0]  v;
    logic [7:0]   pw;
    int           w, lb, n, ipl, c, sl, st;
    f = '0;
    mode_tab(m, w, lb, n, ipl, pw);
    for (int i = 0; i < n; i++) begin
      case (m)
        4'h4, 4'h5, 4'h7: begin c = i; sl = 0; end
        4'ha: begin c = i / 8; sl = (i / 4) % 2 + 2 * (i % 4); end
        4'hb: begin c = i / 20; sl = (i / 5) % 4 + 4 * (i % 5); end
        default: begin c = i / 2; sl = i % 2; end
      endcase
      v  = s[c*240 + sl*12 +: 12];
      st = (i / ipl) * lb + (i % ipl) * w;
      for (int k = 0; k < w; k++) f[(st + k) / lb * 64 + 63 - (st + k) % lb] = v[w-1-k];
    end
    return f;
  endfunction : exp_frame

  function automatic logic [959:0] rnd_samples();
    logic [959:0] r;
    for (int i = 0; i < 30; i++) begin
      repeat (32) seed = lfsr(seed);
      r[i*32 +: 32] = seed;
    end
    return r;
  endfunction : rnd_samples

  task automatic chk_frame(logic [511:0] got, logic [511:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_frame

  task automatic chk_cfg(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cfg

  always @(posedge ref_clk) begin
    if (!rst && sample_valid && sample_ready === 1'b1 && link_enable &&
        cur_mode inside {[4'h4:4'hb]}) exp_q.push_back(exp_frame(cur_mode, sample_data));
    if (!rst && lane_valid === 1'b1 && lane_ready === 1'b1) begin
      if (exp_q.size() == 0) chk_cfg(8'h01, 8'h00);
      else begin
        e = exp_q.pop_front();
        chk_frame(lane_data, e);
      end
    end
  end

  // Called at a rising edge; returns at the edge that took the frame.
  task automatic send(logic [959:0] d);
    int t;
    sample_valid <= 1'b1;
    sample_data  <= d;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (sample_ready !== 1'b1 && t < 200);
    // A frame that is never taken is a hang of the input side.
    if (sample_ready !== 1'b1) err_total++;
  endtask : send

  task automatic drain();
    for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge ref_clk);
    chk_cfg(8'(exp_q.size()), 8'h00);
  endtask : drain

  task automatic set_mode(logic [3:0] m);
    int         w, lb, n, ipl;
    logic [7:0] pw;
    mode_tab(m, w, lb, n, ipl, pw);
    link_enable      <= 1'b0;
    link_mode_select <= m;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cur_mode = m;
    chk_cfg(lane_power, pw);
    chk_cfg({4'h0, active_mode}, {4'h0, m});
    chk_cfg({4'h0, frame_octets}, 8'(lb / 8));
    chk_cfg({7'h0, mode_error}, {7'h0, pw == 8'h00});
    @(posedge ref_clk);
    link_enable      <= 1'b1;
    link_mode_select <= m ^ 4'h1;
  endtask : set_mode

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    seed = 32'h4c95;
    err_total = 0;
    n_checks = 0;
    rst = 1'b1;
    link_enable = 1'b0;
    link_mode_select = 4'h0;
    sample_valid = 1'b0;
    sample_data = '0;
    halt = 1'b0;
    cur_mode = 4'h0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk_cfg(lane_power, 8'h00);
    chk_cfg({7'h0, mode_error}, 8'h01);
    @(posedge ref_clk);
    for (int m = 3; m < 13; m++) begin
      set_mode(4'(m));
      send({960{1'b1}});
      repeat (6) send(rnd_samples());
      sample_valid <= 1'b0;
      repeat (10) @(posedge ref_clk);
      drain();
      chk_cfg({4'h0, active_mode}, 8'(m));
    end
    // Stall the receiver so the buffer and head word fill, then drain it.
    set_mode(4'h9);
    halt <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 17; i++) send(rnd_samples());
    sample_valid <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_cfg({7'h0, sample_ready}, 8'h00);
    @(posedge ref_clk);
    halt <= 1'b0;
    drain();
    final_report();
  end
endmodule : tb
